// ==== core/cscc_ctrl.sv ====
// clock source configuration block: control register, pin reservation, mode switching
//
// Function
// - first write picking an external mode reserves ext_ref_in_pin, role set by ext_ref_select.
// - first write picking internal or self-clocked mode leaves both oscillator pins unused.
// - first write picking an external mode drives osc_out_pin as oscillator output.
// - oscillator runs low power by default; high amplitude only when osc_high_gain_sel is one.
// - osc_high_gain_sel sits at bit 7, one selects high gain, write-once after reset.
// - only the first write after reset reaches each write-once bit.
// - range bit at position 6, write-once; zero gives prescale 64, one gives 1.
// - range bit acts only in the two external-reference modes.
// - ext_ref_select at bit 5, write-once; one requests crystal, zero external clock.
// - clock_mode_select at bits 4:3 encodes self, engaged internal, bypassed, engaged external.
// - a bypassed-external request waits until ext_ref_clk_ok is one.
// - entering off mode leaves clock_mode_select unchanged.
// - a mode write during an unfinished mode change is ignored.
// - after a first write of 0X, later writes of 1X are blocked until reset.
// - osc_keep_on_in_off at bit 2 chooses whether the oscillator survives off mode.
// - osc_keep_on_in_off is ignored when high gain and high range are both set.
// - clock_loss_detect_disable at bit 1, one disables loss-of-clock detection.
// - after reset the generator runs self-clocked with the fll open loop.
// - mode_status reports the active mode, lagging writes by the crossing delay.
// - ref_status reads zero for external clock and one for crystal reference.
`timescale 1ns/1ps
module cscc_ctrl (
	input  wire logic                        sys_clk_i,         // 50 mhz system clock
	input  wire logic                        rstn_i,            // async active-low reset
	// axi4-lite slave
	input  wire logic [cscc_pkg::ADDR_W-1:0] s_axi_awaddr_i,    // write address
	input  wire logic                        s_axi_awvalid_i,   // write address valid
	output logic                             s_axi_awready_o,   // write address ready
	input  wire logic [31:0]                 s_axi_wdata_i,     // write data
	input  wire logic [3:0]                  s_axi_wstrb_i,     // byte enables
	input  wire logic                        s_axi_wvalid_i,    // write data valid
	output logic                             s_axi_wready_o,    // write data ready
	output logic [1:0]                       s_axi_bresp_o,     // write response
	output logic                             s_axi_bvalid_o,    // write response valid
	input  wire logic                        s_axi_bready_i,    // write response ready
	input  wire logic [cscc_pkg::ADDR_W-1:0] s_axi_araddr_i,    // read address
	input  wire logic                        s_axi_arvalid_i,   // read address valid
	output logic                             s_axi_arready_o,   // read address ready
	output logic [31:0]                      s_axi_rdata_o,     // read data
	output logic [1:0]                       s_axi_rresp_o,     // read response
	output logic                             s_axi_rvalid_o,    // read data valid
	input  wire logic                        s_axi_rready_i,    // read data ready
	// generator side
	input  wire logic                        ext_ref_clk_ok_i,  // external reference valid
	input  wire logic                        off_mode_i,        // generator in off mode
	input  wire logic                        osc_enable_req_i,  // enable request in off mode
	output logic                             ext_ref_in_use_o,  // ext_ref_in_pin reserved
	output logic                             ext_ref_is_osc_o,  // pin is oscillator input
	output logic                             osc_out_oe_o,      // osc_out_pin driven
	output logic                             osc_enable_o,      // oscillator circuit on
	output logic                             osc_high_gain_o,   // high amplitude operation
	output logic [6:0]                       fll_prescale_o,    // fll loop prescale factor
	output logic [1:0]                       clock_mode_o,      // active clock mode
	output logic                             loss_detect_en_o   // loss-of-clock detection on
);

	typedef struct packed {
		logic                        awready;
		logic                        wready;
		logic                        aw_got;
		logic                        w_got;
		logic [cscc_pkg::ADDR_W-1:0] waddr;
		logic [7:0]                  wdata;
		logic                        wlane0;
		logic                        bvalid;
		logic [1:0]                  bresp;
		logic                        arready;
		logic                        rvalid;
		logic [1:0]                  rresp;
		logic [31:0]                 rdata;
		logic [7:0]                  ctrl;
		logic                        first_done;
		logic                        reserved;
		logic                        pending;
		logic [1:0]                  lag;
		logic [1:0]                  active;
		logic                        ref_status;
		logic                        osc_en;
		logic                        high_gain;
		logic [6:0]                  prescale;
		logic                        loss_en;
	} cscc_state_t;

	cscc_state_t q;
	cscc_state_t next_q;

	logic rst_sync_n;
	logic ext_ok;

	// reset is asserted at once and released through two flops
	cscc_sync u_rst_sync (
		.clk_i  (sys_clk_i),
		.rstn_i (rstn_i),
		.d_i    (1'b1),
		.q_o    (rst_sync_n)
	);

	// the reference-good level comes from the analog monitor, off this clock
	cscc_sync u_ext_ok_sync (
		.clk_i  (sys_clk_i),
		.rstn_i (rst_sync_n),
		.d_i    (ext_ref_clk_ok_i),
		.q_o    (ext_ok)
	);

	// next-state logic for bus slave and clock configuration
	always_comb begin
		logic       do_write;
		logic       keep_eff;
		logic       ext_mode;
		logic [7:0] d;
		logic [1:0] req_mode;
		logic [7:0] status;
		logic [1:0] sel_mode;
		do_write = 1'b0;
		keep_eff = 1'b0;
		ext_mode = 1'b0;
		d        = 8'h00;
		req_mode = 2'h0;
		status   = 8'h00;
		sel_mode = 2'h0;
		next_q   = q;

		// write address and data are taken in either order
		if (q.awready && s_axi_awvalid_i) begin
			next_q.awready = 1'b0;
			next_q.aw_got  = 1'b1;
			next_q.waddr   = s_axi_awaddr_i;
		end
		if (q.wready && s_axi_wvalid_i) begin
			next_q.wready = 1'b0;
			next_q.w_got  = 1'b1;
			next_q.wdata  = s_axi_wdata_i[7:0];
			next_q.wlane0 = s_axi_wstrb_i[0];
		end

		// both halves present: perform the write and raise the response
		if (q.aw_got && q.w_got && !q.bvalid) begin
			next_q.aw_got = 1'b0;
			next_q.w_got  = 1'b0;
			next_q.bvalid = 1'b1;
			if (q.waddr == cscc_pkg::OFF_CTRL1) begin
				next_q.bresp = cscc_pkg::RESP_OKAY;
				do_write     = q.wlane0;
			end else if (q.waddr == cscc_pkg::OFF_STATUS) begin
				next_q.bresp = cscc_pkg::RESP_OKAY;  // read-only, write dropped
			end else begin
				next_q.bresp = cscc_pkg::RESP_SLVERR;
			end
		end

		// ready reopens only after the response is accepted: one write at a time
		if (q.bvalid && s_axi_bready_i) begin
			next_q.bvalid  = 1'b0;
			next_q.awready = 1'b1;
			next_q.wready  = 1'b1;
		end

		// control register write
		d        = q.wdata;
		req_mode = {d[cscc_pkg::BIT_MODE_HI], d[cscc_pkg::BIT_MODE_LO]};
		if (do_write) begin
			if (!q.first_done) begin
				// first write sets every field and freezes the pin decision
				next_q.first_done = 1'b1;
				next_q.ctrl       = {d[7:1], 1'b0};
				next_q.reserved   = req_mode[1];
				next_q.ref_status = d[cscc_pkg::BIT_REF_SELECT];
			end else begin
				// write-once bits keep their first value until reset
				next_q.ctrl[cscc_pkg::BIT_KEEP_ON] = d[cscc_pkg::BIT_KEEP_ON];
				next_q.ctrl[cscc_pkg::BIT_LOSS_DIS] = d[cscc_pkg::BIT_LOSS_DIS];
			end
			// mode write accepted only when no change is in flight and pins allow it
			if (!q.pending && (req_mode != q.active)
				&& (!q.first_done || q.reserved || !req_mode[1])) begin
				next_q.ctrl[cscc_pkg::BIT_MODE_HI] = req_mode[1];
				next_q.ctrl[cscc_pkg::BIT_MODE_LO] = req_mode[0];
				next_q.pending = 1'b1;
				next_q.lag     = cscc_pkg::MODE_SYNC_CYCLES;
			end else if (q.first_done || q.pending) begin
				// a refused mode write leaves the field as it was
				next_q.ctrl[cscc_pkg::BIT_MODE_HI] = q.ctrl[cscc_pkg::BIT_MODE_HI];
				next_q.ctrl[cscc_pkg::BIT_MODE_LO] = q.ctrl[cscc_pkg::BIT_MODE_LO];
			end
		end

		// mode change crosses into the generator; off mode only pauses it
		if (q.pending && !off_mode_i) begin
			if (q.lag != 2'h0) begin
				next_q.lag = q.lag - 2'h1;
			end else if ({q.ctrl[cscc_pkg::BIT_MODE_HI], q.ctrl[cscc_pkg::BIT_MODE_LO]}
				!= cscc_pkg::MODE_FLL_BYP_EXT || ext_ok) begin
				next_q.active  = {q.ctrl[cscc_pkg::BIT_MODE_HI],
					q.ctrl[cscc_pkg::BIT_MODE_LO]};
				next_q.pending = 1'b0;
			end
		end

		// oscillator and loop settings follow the registered configuration
		ext_mode = q.active[1];
		next_q.high_gain = q.reserved && q.ctrl[cscc_pkg::BIT_HIGH_GAIN];
		next_q.prescale  = (ext_mode && !q.ctrl[cscc_pkg::BIT_RANGE])
			? cscc_pkg::PRESCALE_LOW : cscc_pkg::PRESCALE_HIGH;
		next_q.loss_en   = !q.ctrl[cscc_pkg::BIT_LOSS_DIS];
		// with high gain and high range the keep-on bit is treated as zero
		keep_eff = q.ctrl[cscc_pkg::BIT_KEEP_ON]
			&& !(q.ctrl[cscc_pkg::BIT_HIGH_GAIN] && q.ctrl[cscc_pkg::BIT_RANGE]);
		// the amplifier follows the requested mode: a crystal must swing before
		// the reference can be judged good, else a bypass request would never land
		sel_mode = {q.ctrl[cscc_pkg::BIT_MODE_HI], q.ctrl[cscc_pkg::BIT_MODE_LO]};
		if (!q.reserved || !q.ref_status) begin
			next_q.osc_en = 1'b0;
		end else if (!off_mode_i) begin
			next_q.osc_en = sel_mode[1];
		end else if (keep_eff) begin
			next_q.osc_en = sel_mode[1];
		end else begin
			next_q.osc_en = osc_enable_req_i
				&& (sel_mode == cscc_pkg::MODE_FLL_BYP_EXT);
		end

		// status word: active mode, reference, reference good, busy, flags
		status[cscc_pkg::STAT_MODE_HI]  = q.active[1];
		status[cscc_pkg::STAT_MODE_LO]  = q.active[0];
		status[cscc_pkg::STAT_REF]      = q.ref_status;
		status[cscc_pkg::STAT_EXT_OK]   = ext_ok;
		status[cscc_pkg::STAT_PENDING]  = q.pending;
		status[cscc_pkg::STAT_FIRST]    = q.first_done;
		status[cscc_pkg::STAT_RESERVED] = q.reserved;

		// read channel: one read under way at a time
		if (q.arready && s_axi_arvalid_i) begin
			next_q.arready = 1'b0;
			next_q.rvalid  = 1'b1;
			next_q.rresp   = cscc_pkg::RESP_OKAY;
			if (s_axi_araddr_i == cscc_pkg::OFF_CTRL1) begin
				next_q.rdata = {24'h00_0000, q.ctrl};
			end else if (s_axi_araddr_i == cscc_pkg::OFF_STATUS) begin
				next_q.rdata = {24'h00_0000, status};
			end else begin
				next_q.rdata = 32'h0000_0000;
				next_q.rresp = cscc_pkg::RESP_SLVERR;
			end
		end
		if (q.rvalid && s_axi_rready_i) begin
			next_q.rvalid  = 1'b0;
			next_q.arready = 1'b1;
		end
	end

	// single state register; reset puts the generator in self-clocked mode
	always_ff @(posedge sys_clk_i or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			q            <= '0;
			q.awready    <= 1'b1;
			q.wready     <= 1'b1;
			q.arready    <= 1'b1;
			q.ctrl       <= cscc_pkg::CTRL1_RESET;
			q.active     <= cscc_pkg::MODE_SELF_CLOCKED;
			q.prescale   <= cscc_pkg::PRESCALE_HIGH;
			q.loss_en    <= 1'b1;
		end else begin
			q <= next_q;
		end
	end

	// outputs come straight from the state register
	assign s_axi_awready_o  = q.awready;
	assign s_axi_wready_o   = q.wready;
	assign s_axi_bresp_o    = q.bresp;
	assign s_axi_bvalid_o   = q.bvalid;
	assign s_axi_arready_o  = q.arready;
	assign s_axi_rdata_o    = q.rdata;
	assign s_axi_rresp_o    = q.rresp;
	assign s_axi_rvalid_o   = q.rvalid;
	assign ext_ref_in_use_o = q.reserved;
	assign ext_ref_is_osc_o = q.ref_status;
	assign osc_out_oe_o     = q.reserved;
	assign osc_enable_o     = q.osc_en;
	assign osc_high_gain_o  = q.high_gain;
	assign fll_prescale_o   = q.prescale;
	assign clock_mode_o     = q.active;
	assign loss_detect_en_o = q.loss_en;

endmodule : cscc_ctrl

// ==== core/cscc_pkg.sv ====
// package of constants shared by the clock source configuration block
package cscc_pkg;

	// register byte addresses on the axi4-lite slave
	localparam logic [7:0] OFF_CTRL1  = 8'h00;
	localparam logic [7:0] OFF_STATUS = 8'h04;
	localparam int         ADDR_W     = 8;

	// field positions in clock_gen_control_1
	localparam int BIT_HIGH_GAIN  = 7;
	localparam int BIT_RANGE      = 6;
	localparam int BIT_REF_SELECT = 5;
	localparam int BIT_MODE_HI    = 4;
	localparam int BIT_MODE_LO    = 3;
	localparam int BIT_KEEP_ON    = 2;
	localparam int BIT_LOSS_DIS   = 1;

	// field positions in the status register
	localparam int STAT_MODE_HI   = 7;
	localparam int STAT_MODE_LO   = 6;
	localparam int STAT_REF       = 5;
	localparam int STAT_EXT_OK    = 4;
	localparam int STAT_PENDING   = 3;
	localparam int STAT_FIRST     = 2;
	localparam int STAT_RESERVED  = 1;

	// reset value: self-clocked, low power, low range, external clock requested
	localparam logic [7:0] CTRL1_RESET = 8'h00;

	// clock mode encodings
	localparam logic [1:0] MODE_SELF_CLOCKED  = 2'h0;
	localparam logic [1:0] MODE_FLL_ENG_INT   = 2'h1;
	localparam logic [1:0] MODE_FLL_BYP_EXT   = 2'h2;
	localparam logic [1:0] MODE_FLL_ENG_EXT   = 2'h3;

	// fll loop prescale factor for each range
	localparam logic [6:0] PRESCALE_LOW  = 7'h40;
	localparam logic [6:0] PRESCALE_HIGH = 7'h01;

	// cycles a mode request spends crossing into the generator before it is active
	localparam logic [1:0] MODE_SYNC_CYCLES = 2'h3;

	// axi responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : cscc_pkg

// ==== core/cscc_sync.sv ====
// two flip-flop synchroniser for one level
`timescale 1ns/1ps
module cscc_sync (
	input  wire logic clk_i,   // destination clock
	input  wire logic rstn_i,  // asynchronous active-low reset
	input  wire logic d_i,     // level from another domain
	output logic      q_o      // synchronised level
);
	logic stage1;
	logic stage2;

	// first stage feeds only the second stage
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			stage1 <= 1'b0;
			stage2 <= 1'b0;
		end else begin
			stage1 <= d_i;
			stage2 <= stage1;
		end
	end

	assign q_o = stage2;

endmodule : cscc_sync

// ==== verification/cscc_ctrl_monitor.sv ====
// concurrent checks on the clock source configuration block ports
`timescale 1ns/1ps
module cscc_ctrl_monitor (
	input wire logic       sys_clk_i,        // system clock
	input wire logic       rstn_i,           // async reset, active low
	input wire logic       s_axi_awready_o,  // write address ready
	input wire logic       s_axi_bvalid_o,   // write response valid
	input wire logic       ext_ref_clk_ok_i, // reference valid
	input wire logic       ext_ref_in_use_o, // reference pin reserved
	input wire logic       ext_ref_is_osc_o, // crystal reference
	input wire logic       osc_out_oe_o,     // oscillator pin driven
	input wire logic       osc_enable_o,     // oscillator on
	input wire logic       osc_high_gain_o,  // high amplitude
	input wire logic [6:0] fll_prescale_o,   // loop prescale
	input wire logic [1:0] clock_mode_o      // active mode
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rstn_i);
	// the cycle the generator lands in bypassed external mode
	sequence s_byp_entry;
		$rose(clock_mode_o == cscc_pkg::MODE_FLL_BYP_EXT);
	endsequence
	// the ok level crosses two flops, so look back over the whole crossing window
	sequence s_ok_seen;
		$past(ext_ref_clk_ok_i, 2) || $past(ext_ref_clk_ok_i, 3) || $past(ext_ref_clk_ok_i, 4);
	endsequence
	a_pin_pair: assert property (osc_out_oe_o == ext_ref_in_use_o)
		else $error("oscillator pin drive differs from reservation");
	a_pin_frozen: assert property (!$fell(ext_ref_in_use_o))
		else $error("pin reservation released without reset");
	a_ref_once: assert property (!$fell(ext_ref_is_osc_o))
		else $error("reference status cleared without reset");
	a_prescale_int: assert property (!clock_mode_o[1] |=> fll_prescale_o == 7'h01)
		else $error("range bit acted in an internal mode");
	// the range bit is write-once, so the factor cannot move while external
	a_prescale_val: assert property ($past(clock_mode_o[1]) && clock_mode_o[1] |=> $stable(fll_prescale_o))
		else $error("prescale moved while in an external mode");
	a_gain_pin: assert property (osc_high_gain_o |-> ext_ref_in_use_o)
		else $error("high gain without a reserved oscillator");
	a_mode_pin: assert property (clock_mode_o[1] |-> ext_ref_in_use_o)
		else $error("external mode active while pin unreserved");
	a_byp_wait: assert property (s_byp_entry |-> s_ok_seen)
		else $error("bypass entered before the reference was valid");
	a_osc_pin: assert property (osc_enable_o |-> ext_ref_in_use_o && ext_ref_is_osc_o)
		else $error("oscillator on without a reserved crystal");
	a_reset_self: assert property ($rose(rstn_i) |-> clock_mode_o == 2'h0 && !osc_enable_o)
		else $error("not self clocked after reset");
	a_resp_busy: assert property (s_axi_bvalid_o |-> !s_axi_awready_o)
		else $error("address accepted while a response is pending");
endmodule : cscc_ctrl_monitor

// ==== verification/cscc_osc_out_pin_model.sv ====
// behavioural crystal or square-wave source on the reference pins
`timescale 1ns/1ps
module cscc_osc_out_pin_model #(parameter int STARTUP = 6) (
	input  wire logic sys_clk_i, // system clock
	input  wire logic present_i, // source fitted and running
	input  wire logic in_use_i,  // pins reserved by the device
	input  wire logic is_osc_i,  // crystal rather than square wave
	input  wire logic osc_run_i, // oscillator amplifier enabled
	output logic      ok_o       // reference judged valid
);
	int cnt = 0;
	// a crystal only swings while the amplifier runs and needs a startup time
	always @(posedge sys_clk_i) begin
		if (!present_i || !in_use_i || (is_osc_i && !osc_run_i))
			cnt <= 0;
		else if (cnt < STARTUP)
			cnt <= cnt + 1;
	end
	assign ok_o = (cnt == STARTUP);
endmodule : cscc_osc_out_pin_model

// ==== verification/tb.sv ====
// self-checking bench for the clock source configuration block
`timescale 1ns/1ps
module tb;
	logic        clk, rstn, awv, wv, bry, arv, rry, off, req, present;
	logic        awr, wrd, bv, arr, rv, use_pin, isosc, oe, osc, hg, lde, ok;
	logic [7:0]  awa, ara;
	logic [31:0] wd, rdat;
	logic [1:0]  br, rr, mode;
	logic [6:0]  pre;
	int          mismatches, n_compared;

	cscc_ctrl cscc_ctrl_i (.sys_clk_i(clk), .rstn_i(rstn), .s_axi_awaddr_i(awa),
		.s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hf),
		.s_axi_wvalid_i(wv), .s_axi_wready_o(wrd), .s_axi_bresp_o(br), .s_axi_bvalid_o(bv),
		.s_axi_bready_i(bry), .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
		.s_axi_rdata_o(rdat), .s_axi_rresp_o(rr), .s_axi_rvalid_o(rv), .s_axi_rready_i(rry),
		.ext_ref_clk_ok_i(ok), .off_mode_i(off), .osc_enable_req_i(req), .ext_ref_in_use_o(use_pin),
		.ext_ref_is_osc_o(isosc), .osc_out_oe_o(oe), .osc_enable_o(osc), .osc_high_gain_o(hg),
		.fll_prescale_o(pre), .clock_mode_o(mode), .loss_detect_en_o(lde));
	cscc_osc_out_pin_model cscc_osc_out_pin_model_i (.sys_clk_i(clk), .present_i(present), .in_use_i(use_pin),
		.is_osc_i(isosc), .osc_run_i(osc), .ok_o(ok));

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	task automatic summarize;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : summarize

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// a used-up bound counts as a mismatch and ends the run
	task automatic tmo(input int n);
		if (n >= 60) begin
			mismatches++;
			$display("[FAIL] %0t wait ran out", $time);
			summarize();
		end
	endtask : tmo

	// address and data offered together, bready held until the response is seen
	task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
		int n;
		awa <= a;
		wd <= v;
		awv <= 1'b1;
		wv <= 1'b1;
		bry <= 1'b1;
		for (n = 0; n < 60; n++) begin
			@(posedge clk);
			if (awr) awv <= 1'b0;
			if (wrd) wv <= 1'b0;
			if (bv) break;
		end
		tmo(n);
		chk(br, er);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
		int n;
		ara <= a;
		arv <= 1'b1;
		rry <= 1'b1;
		for (n = 0; n < 60; n++) begin
			@(posedge clk);
			if (arr) arv <= 1'b0;
			if (rv) break;
		end
		tmo(n);
		chk(rdat, exp);
		chk(rr, er);
	endtask : rd

	task automatic wait_mode(input logic [1:0] m);
		int n;
		for (n = 0; n < 60 && mode !== m; n++)
			@(posedge clk);
		tmo(n);
	endtask : wait_mode

	task automatic do_reset;
		rstn <= 1'b0;
		repeat (12) @(posedge clk);
		rstn <= 1'b1;
		repeat (3) @(posedge clk);
	endtask : do_reset

	// reset state, then a first write reserving a crystal in engaged external mode
	task automatic t_first;
		chk({use_pin, oe, osc, hg, lde, mode, pre}, 32'h0000_0201);
		rd(cscc_pkg::OFF_CTRL1, 32'h0000_0000, cscc_pkg::RESP_OKAY);
		rd(8'h10, 32'h0000_0000, cscc_pkg::RESP_SLVERR);
		wr(cscc_pkg::OFF_STATUS, 32'h0000_00ff, cscc_pkg::RESP_OKAY);
		wr(8'h10, 32'h0000_00ff, cscc_pkg::RESP_SLVERR);
		wr(cscc_pkg::OFF_CTRL1, 32'h0000_00ba, cscc_pkg::RESP_OKAY);
		repeat (3) @(posedge clk);
		chk({use_pin, isosc, oe, hg, lde}, 32'h0000_001e);
		wait_mode(cscc_pkg::MODE_FLL_ENG_EXT);
		repeat (3) @(posedge clk);
		chk({osc, pre}, {1'b1, cscc_pkg::PRESCALE_LOW});
		$display("test first write done");
	endtask : t_first

	// later writes reach only the writable fields
	task automatic t_once;
		wr(cscc_pkg::OFF_CTRL1, 32'h0000_0042, cscc_pkg::RESP_OKAY);
		rd(cscc_pkg::OFF_CTRL1, 32'h0000_00a2, cscc_pkg::RESP_OKAY);
		wait_mode(cscc_pkg::MODE_SELF_CLOCKED);
		repeat (3) @(posedge clk);
		chk({hg, lde, osc, pre}, {3'h4, cscc_pkg::PRESCALE_HIGH});
		wr(cscc_pkg::OFF_CTRL1, 32'h0000_00b8, cscc_pkg::RESP_OKAY);
		wr(cscc_pkg::OFF_CTRL1, 32'h0000_00a8, cscc_pkg::RESP_OKAY);
		rd(cscc_pkg::OFF_CTRL1, 32'h0000_00b8, cscc_pkg::RESP_OKAY);
		wait_mode(cscc_pkg::MODE_FLL_ENG_EXT);
		repeat (8) @(posedge clk);
		chk(mode, cscc_pkg::MODE_FLL_ENG_EXT);
		$display("test write once done");
	endtask : t_once

	// bypass waits for a valid reference, then off-mode oscillator handling
	task automatic t_bypass_off;
		present <= 1'b0;
		repeat (8) @(posedge clk);
		wr(cscc_pkg::OFF_CTRL1, 32'h0000_00b0, cscc_pkg::RESP_OKAY);
		repeat (20) @(posedge clk);
		chk(mode, cscc_pkg::MODE_FLL_ENG_EXT);
		present <= 1'b1;
		wait_mode(cscc_pkg::MODE_FLL_BYP_EXT);
		off <= 1'b1;
		repeat (4) @(posedge clk);
		chk({osc, mode}, 32'h0000_0002);
		req <= 1'b1;
		repeat (4) @(posedge clk);
		chk(osc, 1'b1);
		wr(cscc_pkg::OFF_CTRL1, 32'h0000_00b4, cscc_pkg::RESP_OKAY);
		req <= 1'b0;
		repeat (4) @(posedge clk);
		chk(osc, 1'b1);
		off <= 1'b0;
		$display("test bypass and off done");
	endtask : t_bypass_off

	// internal first write keeps the pins free and locks out external modes
	task automatic t_lock;
		do_reset();
		wr(cscc_pkg::OFF_CTRL1, 32'h0000_0008, cscc_pkg::RESP_OKAY);
		wait_mode(cscc_pkg::MODE_FLL_ENG_INT);
		wr(cscc_pkg::OFF_CTRL1, 32'h0000_0018, cscc_pkg::RESP_OKAY);
		repeat (10) @(posedge clk);
		rd(cscc_pkg::OFF_CTRL1, 32'h0000_0008, cscc_pkg::RESP_OKAY);
		chk({use_pin, oe, mode}, 32'h0000_0001);
		$display("test lockout done");
	endtask : t_lock

	// keep-on bit has no effect with high gain and high range
	task automatic t_ignore;
		do_reset();
		wr(cscc_pkg::OFF_CTRL1, 32'h0000_00f4, cscc_pkg::RESP_OKAY);
		wait_mode(cscc_pkg::MODE_FLL_BYP_EXT);
		off <= 1'b1;
		repeat (4) @(posedge clk);
		chk({osc, pre}, {1'b0, cscc_pkg::PRESCALE_HIGH});
		off <= 1'b0;
		$display("test keep-on ignored done");
	endtask : t_ignore

	initial begin
		{rstn, awv, wv, bry, arv, rry, off, req} = 8'h00;
		present = 1'b1;
		awa = 8'h00;
		ara = 8'h00;
		wd = 32'h0000_0000;
		mismatches = 0;
		n_compared = 0;
		do_reset();
		t_first();
		t_once();
		t_bypass_off();
		t_lock();
		t_ignore();
		summarize();
	end
endmodule : tb

bind cscc_ctrl cscc_ctrl_monitor cscc_ctrl_monitor_i (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
	.s_axi_awready_o(s_axi_awready_o), .s_axi_bvalid_o(s_axi_bvalid_o),
	.ext_ref_clk_ok_i(ext_ref_clk_ok_i), .ext_ref_in_use_o(ext_ref_in_use_o),
	.ext_ref_is_osc_o(ext_ref_is_osc_o), .osc_out_oe_o(osc_out_oe_o), .osc_enable_o(osc_enable_o),
	.osc_high_gain_o(osc_high_gain_o), .fll_prescale_o(fll_prescale_o),
	.clock_mode_o(clock_mode_o));
